// ==== osmux_assertions.sv ====
// osmux_assertions: port-level checks of the output clock source mux
// assumes binding to osmux_top, sources held as levels by the bench
`timescale 1ns/1ps
module osmux_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // status, option and sources
  input wire logic PLL_OFF,
  input wire logic [1:0] PKG_OPT,
  input wire logic REF_PRE,
  input wire logic [4:0] HS_DIV,
  // selectors and outputs
  input wire logic [7:0] SEL_FIRST,
  input wire logic [11:0] SEL_SECOND,
  input wire logic [11:0] OUT_CLK
);
  // one clock domain, checks paused in reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // register port behaviour
  AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero after idle cycle");
  AST_RD_UNMAPPED: assert property (RD && (ADDR < 8'h27 || ADDR > 8'h2A) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_WR_G2_FIRST: assert property (WR && ADDR == 8'h27
    |=> SEL_FIRST[1:0] == $past(WDATA[1:0]))
    else $error("group 2 first selector not updated");
  AST_WR_G5_SECOND: assert property (WR && ADDR == 8'h2A && !PLL_OFF
    |=> SEL_SECOND[11:9] == $past(WDATA[6:4]))
    else $error("group 5 second selector not updated");
  // pll off forcing
  AST_PLL_FORCE: assert property (PLL_OFF |=> SEL_SECOND == 12'hFFF)
    else $error("second selectors not forced while pll off");
  AST_RD_FORCE: assert property (RD && ADDR == 8'h28 && PLL_OFF |=> RDATA[6:4] == 3'h7)
    else $error("read of forced selector not 7");
  // output routing
  AST_OUT_UNUSED: assert property (OUT_CLK[1:0] == 2'h0 && (PKG_OPT != 2'h2 || !OUT_CLK[2]))
    else $error("unused output driven");
  AST_PASS_G3: assert property (PKG_OPT == 2'h0 && SEL_SECOND[5:3] == 3'h7 && SEL_FIRST[3:2] == 2'h0
    |-> OUT_CLK[3] == REF_PRE)
    else $error("group 3 pass-through wrong");
  AST_HS_G4: assert property (PKG_OPT == 2'h1 && SEL_SECOND[8:6] == 3'h1
    |-> OUT_CLK[6] == HS_DIV[1])
    else $error("group 4 divider route wrong");
  // main scenarios
  COV_WR_G4: cover property (WR && ADDR == 8'h29);
  COV_RD_PLL: cover property (RD && PLL_OFF);
  COV_LARGE: cover property (PKG_OPT == 2'h2 && SEL_SECOND[2:0] == 3'h5);
endmodule : osmux_assertions

bind osmux_top osmux_assertions u_osmux_assertions (.CLK(CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PLL_OFF(PLL_OFF), .PKG_OPT(PKG_OPT),
  .REF_PRE(REF_PRE), .HS_DIV(HS_DIV), .SEL_FIRST(SEL_FIRST), .SEL_SECOND(SEL_SECOND),
  .OUT_CLK(OUT_CLK));

// ==== osmux_group.sv ====
// osmux_group: two-stage source mux of one output group
// assumes selector values that are already forced for a disabled pll
`timescale 1ns/1ps
module osmux_group (
  // selectors in, group clock out
  osmux_sel_if.mux bus,
  // reference and buffer sources
  input wire logic ref_pre,
  input wire logic ref_post,
  input wire logic buf_two,
  input wire logic buf_three,
  // divider sources
  input wire logic [osmux_pkg::OSMUX_HS_DIVS-1:0] hs_div,
  input wire logic [osmux_pkg::OSMUX_INT_DIVS-1:0] int_div
);

  logic first_clk;

  // first stage: reference before or after prescaler, or an input buffer
  always_comb begin
    first_clk = 1'b0;
    unique case (bus.first_sel)
      osmux_pkg::OSMUX_FS_REF_PRE: first_clk = ref_pre;
      osmux_pkg::OSMUX_FS_REF_POST: first_clk = ref_post;
      osmux_pkg::OSMUX_FS_BUF_TWO: first_clk = buf_two;
      osmux_pkg::OSMUX_FS_BUF_THREE: first_clk = buf_three;
    endcase
  end

  // second stage: a divider, or fall through to the first stage
  always_comb begin
    bus.group_clk = 1'b0;
    unique case (bus.second_sel)
      osmux_pkg::OSMUX_SS_HS0: bus.group_clk = hs_div[0];
      osmux_pkg::OSMUX_SS_HS1: bus.group_clk = hs_div[1];
      osmux_pkg::OSMUX_SS_HS2: bus.group_clk = hs_div[2];
      osmux_pkg::OSMUX_SS_HS3: bus.group_clk = hs_div[3];
      osmux_pkg::OSMUX_SS_HS4: bus.group_clk = hs_div[4];
      osmux_pkg::OSMUX_SS_INT0: bus.group_clk = int_div[0];
      osmux_pkg::OSMUX_SS_INT1: bus.group_clk = int_div[1];
      osmux_pkg::OSMUX_SS_PASS: bus.group_clk = first_clk;
    endcase
  end

endmodule : osmux_group

// ==== osmux_pkg.sv ====
// osmux_pkg: offsets, field layout, reset values and codes of the output clock source mux
// assumes byte-wide registers reached over a plain address/strobe port
package osmux_pkg;

  // register port widths
  localparam int OSMUX_ADDR_W = 8;
  localparam int OSMUX_DATA_W = 8;

  // number of output groups held here (groups 2 to 5) and output count
  localparam int OSMUX_GROUPS = 4;
  localparam int OSMUX_FIRST_GROUP = 2;
  localparam int OSMUX_OUTPUTS = 12;

  // one byte per group, group 2 at the lowest offset
  localparam logic [7:0] OSMUX_GROUP2_SEL_ADDR = 8'h27;
  localparam logic [7:0] OSMUX_GROUP3_SEL_ADDR = 8'h28;
  localparam logic [7:0] OSMUX_GROUP4_SEL_ADDR = 8'h29;
  localparam logic [7:0] OSMUX_GROUP5_SEL_ADDR = 8'h2A;

  // field positions and widths inside a group byte
  localparam int OSMUX_FIRST_LSB = 0;
  localparam int OSMUX_FIRST_W = 2;
  localparam int OSMUX_SECOND_LSB = 4;
  localparam int OSMUX_SECOND_W = 3;

  // reset values of the two selectors
  localparam logic [1:0] OSMUX_FIRST_RST = 2'h0;
  localparam logic [2:0] OSMUX_SECOND_RST = 3'h7;

  // first-stage codes
  localparam logic [1:0] OSMUX_FS_REF_PRE = 2'h0;
  localparam logic [1:0] OSMUX_FS_REF_POST = 2'h1;
  localparam logic [1:0] OSMUX_FS_BUF_TWO = 2'h2;
  localparam logic [1:0] OSMUX_FS_BUF_THREE = 2'h3;

  // second-stage codes
  localparam logic [2:0] OSMUX_SS_HS0 = 3'h0;
  localparam logic [2:0] OSMUX_SS_HS1 = 3'h1;
  localparam logic [2:0] OSMUX_SS_HS2 = 3'h2;
  localparam logic [2:0] OSMUX_SS_HS3 = 3'h3;
  localparam logic [2:0] OSMUX_SS_HS4 = 3'h4;
  localparam logic [2:0] OSMUX_SS_INT0 = 3'h5;
  localparam logic [2:0] OSMUX_SS_INT1 = 3'h6;
  localparam logic [2:0] OSMUX_SS_PASS = 3'h7;

  // package option codes on the option input
  localparam logic [1:0] OSMUX_PKG_SMALL = 2'h0;
  localparam logic [1:0] OSMUX_PKG_MIDDLE = 2'h1;
  localparam logic [1:0] OSMUX_PKG_LARGE = 2'h2;

  // source counts
  localparam int OSMUX_HS_DIVS = 5;
  localparam int OSMUX_INT_DIVS = 2;

endpackage : osmux_pkg

// ==== osmux_sel_if.sv ====
// osmux_sel_if: selector values to one group mux and the clock it returns
// assumes one instance per group inside the top module
`timescale 1ns/1ps
interface osmux_sel_if;
  logic [osmux_pkg::OSMUX_FIRST_W-1:0] first_sel;
  logic [osmux_pkg::OSMUX_SECOND_W-1:0] second_sel;
  logic group_clk;

  // control end drives selectors, mux end returns the group clock
  modport ctrl (output first_sel, output second_sel, input group_clk);
  modport mux (input first_sel, input second_sel, output group_clk);
endinterface : osmux_sel_if

// ==== osmux_tb.sv ====
// osmux_tb: register, forcing and routing tests of the output clock source mux
// assumes sources held as static levels so each route shows as a level
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic pll_off = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [1:0] pkg_opt = 2'h0;
  logic [10:0] src = 11'h000;
  logic [7:0] rdata;
  logic [7:0] sel_first;
  logic [11:0] sel_second;
  logic [11:0] out_clk;
  logic [1:0] mf [4];
  logic [2:0] ms [4];
  int num_errors = 0;
  int cmp_count = 0;
  // each pattern is one bit of the source index, the last one all high
  localparam logic [10:0] PATS [5] = '{11'h2AA, 11'h4CC, 11'h0F0, 11'h700, 11'h7FF};
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  osmux_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .PLL_OFF(pll_off), .PKG_OPT(pkg_opt), .REF_PRE(src[0]), .REF_POST(src[1]),
    .INBUF_TWO(src[2]), .INBUF_THREE(src[3]), .HS_DIV(src[8:4]), .INT_DIV(src[10:9]),
    .SEL_FIRST(sel_first), .SEL_SECOND(sel_second), .OUT_CLK(out_clk));
  // compare and count
  task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // one bus cycle, signals change 1 ns after the edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_s <= w;
    rd_s <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1;
  endtask : bus
  function automatic logic [7:0] rexp(input int g);
    return {1'b0, pll_off ? 3'h7 : ms[g], 2'h0, mf[g]};
  endfunction : rexp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    if (a >= 8'h27 && a <= 8'h2A) begin
      mf[a - 8'h27] = d[1:0];
      ms[a - 8'h27] = d[6:4];
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    chk("rdata", {4'h0, rdata},
      {4'h0, (a >= 8'h27 && a <= 8'h2A) ? rexp(a - 8'h27) : 8'h00});
  endtask : rd
  // expected outputs from group clocks and package option
  function automatic logic [11:0] exp_out(input logic [1:0] opt);
    logic [3:0] g;
    logic [11:0] o;
    o = 12'h000;
    for (int i = 0; i < 4; i++) g[i] = (pll_off || ms[i] == 3'h7) ? src[mf[i]] : src[4 + ms[i]];
    case (opt)
      2'h0: o[5:2] = g;
      2'h1: o[7:2] = {g[3], g[2], {2{g[1]}}, {2{g[0]}}};
      2'h2: o[11:3] = {{2{g[3]}}, g[2], {3{g[1]}}, {3{g[0]}}};
      default: o = 12'h000;
    endcase
    return o;
  endfunction : exp_out
  // selectors, then every option under every source pattern
  task automatic check_all;
    logic [11:0] es;
    logic [7:0] ef;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    for (int g = 0; g < 4; g++) begin
      ef[2*g +: 2] = mf[g];
      es[3*g +: 3] = pll_off ? 3'h7 : ms[g];
    end
    chk("sel_first", {4'h0, sel_first}, {4'h0, ef});
    chk("sel_second", sel_second, es);
    for (int o = 0; o < 4; o++) begin
      for (int p = 0; p < 5; p++) begin
        // one clock edge per option and pattern so the checker sees each route
        pkg_opt <= 2'(o);
        src <= PATS[p];
        @(posedge clk);
        #1;
        chk("out_clk", out_clk, exp_out(2'(o)));
      end
    end
  endtask : check_all
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    for (int g = 0; g < 4; g++) begin
      mf[g] = 2'h0;
      ms[g] = 3'h7;
    end
    repeat (3) @(posedge clk);
    #1;
    rst <= 1'b0;
    for (int g = 0; g < 4; g++) rd(8'h27 + 8'(g));
    check_all();
    $display("test reset done");
    // every code in every group, ignored bits set, writes and reads back to back
    for (int k = 0; k < 8; k++) begin
      for (int g = 0; g < 4; g++) wr(8'h27 + 8'(g), {1'b1, 3'(k + g), 2'h3, 2'(k + g)});
      for (int g = 0; g < 4; g++) rd(8'h27 + 8'(g));
      check_all();
    end
    $display("test codes done");
    pll_off <= 1'b1;
    wr(8'h29, 8'h52);
    rd(8'h28);
    rd(8'h29);
    check_all();
    pll_off <= 1'b0;
    rd(8'h28);
    rd(8'h29);
    check_all();
    $display("test pll off done");
    wr(8'h2B, 8'h35);
    wr(8'h26, 8'h35);
    rd(8'h2B);
    rd(8'h26);
    rd(8'h2A);
    check_all();
    $display("test unmapped done");
    end_sim();
  end
endmodule : tb

// ==== osmux_top.sv ====
// osmux_top: selector registers of output groups 2 to 5 and the routing of
// each group clock onto the output pins for the chosen package option
// assumes a same-clock register master, a same-clock pll status and a static option
`timescale 1ns/1ps
module osmux_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [osmux_pkg::OSMUX_ADDR_W-1:0] ADDR,
  input wire logic [osmux_pkg::OSMUX_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [osmux_pkg::OSMUX_DATA_W-1:0] RDATA,
  // device status and package option
  input wire logic PLL_OFF,
  input wire logic [1:0] PKG_OPT,
  // clock sources
  input wire logic REF_PRE,
  input wire logic REF_POST,
  input wire logic INBUF_TWO,
  input wire logic INBUF_THREE,
  input wire logic [osmux_pkg::OSMUX_HS_DIVS-1:0] HS_DIV,
  input wire logic [osmux_pkg::OSMUX_INT_DIVS-1:0] INT_DIV,
  // effective selectors per group, group 2 in the low field
  output logic [osmux_pkg::OSMUX_GROUPS*osmux_pkg::OSMUX_FIRST_W-1:0] SEL_FIRST,
  output logic [osmux_pkg::OSMUX_GROUPS*osmux_pkg::OSMUX_SECOND_W-1:0] SEL_SECOND,
  // output clocks, outputs 0 and 1 belong to groups not held here
  output logic [osmux_pkg::OSMUX_OUTPUTS-1:0] OUT_CLK
);

  localparam int FW = osmux_pkg::OSMUX_FIRST_W;
  localparam int SW = osmux_pkg::OSMUX_SECOND_W;
  localparam int NG = osmux_pkg::OSMUX_GROUPS;

  // stored software values and the effective values used by the muxes
  logic [FW-1:0] first_q [NG];
  logic [FW-1:0] first_d [NG];
  logic [SW-1:0] second_q [NG];
  logic [SW-1:0] second_d [NG];
  logic [SW-1:0] eff_second_q [NG];
  logic [SW-1:0] eff_second_d [NG];
  logic [osmux_pkg::OSMUX_DATA_W-1:0] rdata_q;
  logic [osmux_pkg::OSMUX_DATA_W-1:0] rdata_d;
  logic [NG-1:0] grp_clk;

  // map an address onto a group index, valid flag in the top bit
  function automatic logic [2:0] osmux_decode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      osmux_pkg::OSMUX_GROUP2_SEL_ADDR: r = 3'h4;
      osmux_pkg::OSMUX_GROUP3_SEL_ADDR: r = 3'h5;
      osmux_pkg::OSMUX_GROUP4_SEL_ADDR: r = 3'h6;
      osmux_pkg::OSMUX_GROUP5_SEL_ADDR: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : osmux_decode

  logic [2:0] dec;
  assign dec = osmux_decode(ADDR);

  // next selector values: a write lands in any device mode, no mode gating
  always_comb begin
    for (int g = 0; g < NG; g++) begin
      first_d[g] = first_q[g];
      second_d[g] = second_q[g];
      if (WR && dec[2] && (dec[1:0] == g[1:0])) begin
        first_d[g] = WDATA[osmux_pkg::OSMUX_FIRST_LSB +: FW];
        second_d[g] = WDATA[osmux_pkg::OSMUX_SECOND_LSB +: SW];
      end
      // pll off forces fall-through without touching the stored value
      eff_second_d[g] = PLL_OFF ? osmux_pkg::OSMUX_SS_PASS : second_d[g];
    end
  end

  // register the selectors
  always_ff @(posedge CLK) begin
    for (int g = 0; g < NG; g++) begin
      if (RST) begin
        first_q[g] <= osmux_pkg::OSMUX_FIRST_RST;
        second_q[g] <= osmux_pkg::OSMUX_SECOND_RST;
        eff_second_q[g] <= osmux_pkg::OSMUX_SS_PASS;
      end else begin
        first_q[g] <= first_d[g];
        second_q[g] <= second_d[g];
        eff_second_q[g] <= eff_second_d[g];
      end
    end
  end

  // read data: forced value shown while pll is off, reserved bits zero
  always_comb begin
    rdata_d = '0;
    if (RD && dec[2]) begin
      rdata_d[osmux_pkg::OSMUX_FIRST_LSB +: FW] = first_q[dec[1:0]];
      rdata_d[osmux_pkg::OSMUX_SECOND_LSB +: SW] =
        PLL_OFF ? osmux_pkg::OSMUX_SS_PASS : second_q[dec[1:0]];
    end
  end

  // read data register, valid only in the cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // one two-stage mux per group
  for (genvar g = 0; g < NG; g++) begin : g_grp
    osmux_sel_if u_bus ();
    assign u_bus.first_sel = first_q[g];
    assign u_bus.second_sel = eff_second_q[g];
    assign grp_clk[g] = u_bus.group_clk;
    assign SEL_FIRST[g*FW +: FW] = first_q[g];
    assign SEL_SECOND[g*SW +: SW] = eff_second_q[g];

    osmux_group u_mux (
      .bus(u_bus.mux),
      .ref_pre(REF_PRE),
      .ref_post(REF_POST),
      .buf_two(INBUF_TWO),
      .buf_three(INBUF_THREE),
      .hs_div(HS_DIV),
      .int_div(INT_DIV)
    );
  end

  // group clocks onto output pins per package option, unused pins low
  always_comb begin
    OUT_CLK = '0;
    unique case (PKG_OPT)
      osmux_pkg::OSMUX_PKG_SMALL: begin
        OUT_CLK[2] = grp_clk[0];
        OUT_CLK[3] = grp_clk[1];
        OUT_CLK[4] = grp_clk[2];
        OUT_CLK[5] = grp_clk[3];
      end
      osmux_pkg::OSMUX_PKG_MIDDLE: begin
        OUT_CLK[2] = grp_clk[0];
        OUT_CLK[3] = grp_clk[0];
        OUT_CLK[4] = grp_clk[1];
        OUT_CLK[5] = grp_clk[1];
        OUT_CLK[6] = grp_clk[2];
        OUT_CLK[7] = grp_clk[3];
      end
      osmux_pkg::OSMUX_PKG_LARGE: begin
        OUT_CLK[3] = grp_clk[0];
        OUT_CLK[4] = grp_clk[0];
        OUT_CLK[5] = grp_clk[0];
        OUT_CLK[6] = grp_clk[1];
        OUT_CLK[7] = grp_clk[1];
        OUT_CLK[8] = grp_clk[1];
        OUT_CLK[9] = grp_clk[2];
        OUT_CLK[10] = grp_clk[3];
        OUT_CLK[11] = grp_clk[3];
      end
      default: OUT_CLK = '0; // unused option code drives nothing
    endcase
  end

endmodule : osmux_top
